// *** core/idc_cfg.svh ***
// Constants for the instruction decoder: lengths, cycle counts, opcodes
`ifndef IDC_CFG_SVH
`define IDC_CFG_SVH
`define IDC_CLK_PER_MC      2
`define IDC_MC_ONE          3'h1
`define IDC_MC_TWO          3'h2
`define IDC_MC_FOUR         3'h4
`define IDC_LEN_ONE         2'h1
`define IDC_LEN_TWO         2'h2
`define IDC_LEN_THREE       2'h3
`define IDC_BANK_LSB        0
`define IDC_BANK_W          3
`define IDC_PTR_BIT         0
`define IDC_NOP_OPCODE      8'h00
`endif

// *** core/idc_pkg.sv ***
// Types shared by the instruction decoder
package idc_pkg;
  typedef enum logic [4:0] {
    IDC_CLS_NONE,
    IDC_CLS_ADD,
    IDC_CLS_ADD_WITH_CARRY,
    IDC_CLS_SUBTRACT_WITH_BORROW,
    IDC_CLS_INC,
    IDC_CLS_DEC,
    IDC_CLS_INC_DATA_POINTER,
    IDC_CLS_MULTIPLY,
    IDC_CLS_DIVIDE,
    IDC_CLS_DECIMAL_ADJUST,
    IDC_CLS_AND,
    IDC_CLS_OR,
    IDC_CLS_XOR,
    IDC_CLS_ACC_UNARY,
    IDC_CLS_ROTATE,
    IDC_CLS_MOVE,
    IDC_CLS_LOAD_DATA_POINTER,
    IDC_CLS_CODE_MEMORY_READ,
    IDC_CLS_EXTERNAL_DATA_MOVE,
    IDC_CLS_PUSH,
    IDC_CLS_POP,
    IDC_CLS_EXCHANGE,
    IDC_CLS_LOW_NIBBLE_EXCHANGE,
    IDC_CLS_BIT_SET_CLEAR,
    IDC_CLS_BIT_LOGIC,
    IDC_CLS_BIT_MOVE
  } idc_class_e;
  typedef enum logic [2:0] {
    IDC_OPD_NONE,
    IDC_OPD_ACC,
    IDC_OPD_BANK,
    IDC_OPD_DIRECT,
    IDC_OPD_INDIRECT,
    IDC_OPD_IMMEDIATE,
    IDC_OPD_BIT,
    IDC_OPD_CARRY
  } idc_opd_e;
  typedef enum logic [1:0] {
    IDC_ST_IDLE,
    IDC_ST_FETCH,
    IDC_ST_EXEC
  } idc_state_e;
endpackage : idc_pkg

// *** core/idc_table.sv ***
// Combinational opcode table: length, machine cycles, class, operand kinds
`timescale 1ns/1ps
`include "idc_cfg.svh"
module idc_table
  import idc_pkg::*;
(
  input  wire logic [7:0]  opcode,
  output idc_class_e       op_class,
  output idc_opd_e         dst_kind,
  output idc_opd_e         src_kind,
  output logic [1:0]       len,
  output logic [2:0]       mcycles,
  output logic             known
);
  import idc_pkg::*;

  logic [3:0] lo;
  logic [3:0] hi;

  always_comb begin
    hi       = opcode[7:4];
    lo       = opcode[3:0];
    op_class = IDC_CLS_NONE;
    dst_kind = IDC_OPD_NONE;
    src_kind = IDC_OPD_NONE;
    len      = `IDC_LEN_ONE;
    mcycles  = `IDC_MC_ONE;
    known    = 1'b1;
    // Generic accumulator-operand columns 4..F for rows 0,1,2,3,4,5,6,9,E, except opcode E4
    if (lo >= 4'h4 && (hi <= 4'h6 || hi == 4'h9 || hi == 4'hE) &&
        !(hi == 4'hE && lo == 4'h4)) begin
      dst_kind = (hi <= 4'h1) ? IDC_OPD_NONE : IDC_OPD_ACC;
      case (hi)
        4'h0:    op_class = IDC_CLS_INC;
        4'h1:    op_class = IDC_CLS_DEC;
        4'h2:    op_class = IDC_CLS_ADD;
        4'h3:    op_class = IDC_CLS_ADD_WITH_CARRY;
        4'h4:    op_class = IDC_CLS_OR;
        4'h5:    op_class = IDC_CLS_AND;
        4'h6:    op_class = IDC_CLS_XOR;
        4'h9:    op_class = IDC_CLS_SUBTRACT_WITH_BORROW;
        default: op_class = IDC_CLS_MOVE;
      endcase
      if (lo >= 4'h8) begin
        src_kind = IDC_OPD_BANK;
      end else if (lo >= 4'h6) begin
        src_kind = IDC_OPD_INDIRECT;
      end else if (lo == 4'h5) begin
        src_kind = IDC_OPD_DIRECT;
        len      = `IDC_LEN_TWO;
      end else begin
        src_kind = (hi <= 4'h1) ? IDC_OPD_ACC : IDC_OPD_IMMEDIATE;
        len      = (hi <= 4'h1) ? `IDC_LEN_ONE : `IDC_LEN_TWO;
      end
      if (hi <= 4'h1) begin
        dst_kind = src_kind;
        src_kind = IDC_OPD_NONE;
      end
    end else begin
      case (opcode)
        8'h52, 8'h42, 8'h62: begin
          op_class = (hi == 4'h5) ? IDC_CLS_AND : (hi == 4'h4) ? IDC_CLS_OR : IDC_CLS_XOR;
          dst_kind = IDC_OPD_DIRECT; src_kind = IDC_OPD_ACC; len = `IDC_LEN_TWO;
        end
        8'h53, 8'h43, 8'h63: begin
          op_class = (hi == 4'h5) ? IDC_CLS_AND : (hi == 4'h4) ? IDC_CLS_OR : IDC_CLS_XOR;
          dst_kind = IDC_OPD_DIRECT; src_kind = IDC_OPD_IMMEDIATE;
          len = `IDC_LEN_THREE; mcycles = `IDC_MC_TWO;
        end
        8'h23, 8'h33, 8'h03, 8'h13: begin
          op_class = IDC_CLS_ROTATE; dst_kind = IDC_OPD_ACC;
        end
        8'hA3: begin
          op_class = IDC_CLS_INC_DATA_POINTER; mcycles = `IDC_MC_TWO;
        end
        8'hA4: begin op_class = IDC_CLS_MULTIPLY; mcycles = `IDC_MC_FOUR; end
        8'h84: begin op_class = IDC_CLS_DIVIDE;   mcycles = `IDC_MC_FOUR; end
        8'hD4: begin op_class = IDC_CLS_DECIMAL_ADJUST; dst_kind = IDC_OPD_ACC; end
        8'hE4, 8'hF4, 8'hC4: begin
          op_class = IDC_CLS_ACC_UNARY; dst_kind = IDC_OPD_ACC;
        end
        8'h74: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_ACC;
          src_kind = IDC_OPD_IMMEDIATE; len = `IDC_LEN_TWO;
        end
        8'hF5: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_DIRECT;
          src_kind = IDC_OPD_ACC; len = `IDC_LEN_TWO;
        end
        8'h85, 8'h75: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_DIRECT;
          src_kind = (lo == 4'h5 && hi == 4'h8) ? IDC_OPD_DIRECT : IDC_OPD_IMMEDIATE;
          len = `IDC_LEN_THREE; mcycles = `IDC_MC_TWO;
        end
        8'h86, 8'h87: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_DIRECT;
          src_kind = IDC_OPD_INDIRECT; len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
        end
        8'hF6, 8'hF7: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_INDIRECT; src_kind = IDC_OPD_ACC;
        end
        8'hA6, 8'hA7: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_INDIRECT;
          src_kind = IDC_OPD_DIRECT; len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
        end
        8'h76, 8'h77: begin
          op_class = IDC_CLS_MOVE; dst_kind = IDC_OPD_INDIRECT;
          src_kind = IDC_OPD_IMMEDIATE; len = `IDC_LEN_TWO;
        end
        8'h90: begin
          op_class = IDC_CLS_LOAD_DATA_POINTER; src_kind = IDC_OPD_IMMEDIATE;
          len = `IDC_LEN_THREE; mcycles = `IDC_MC_TWO;
        end
        8'h93, 8'h83: begin
          op_class = IDC_CLS_CODE_MEMORY_READ; dst_kind = IDC_OPD_ACC;
          mcycles = `IDC_MC_TWO;
        end
        8'hE2, 8'hE3, 8'hE0: begin
          op_class = IDC_CLS_EXTERNAL_DATA_MOVE; dst_kind = IDC_OPD_ACC;
          src_kind = (lo == 4'h0) ? IDC_OPD_NONE : IDC_OPD_INDIRECT;
          mcycles = `IDC_MC_TWO;
        end
        8'hF2, 8'hF3, 8'hF0: begin
          op_class = IDC_CLS_EXTERNAL_DATA_MOVE; src_kind = IDC_OPD_ACC;
          dst_kind = (lo == 4'h0) ? IDC_OPD_NONE : IDC_OPD_INDIRECT;
          mcycles = `IDC_MC_TWO;
        end
        8'hC0, 8'hD0: begin
          op_class = (hi == 4'hC) ? IDC_CLS_PUSH : IDC_CLS_POP;
          dst_kind = IDC_OPD_DIRECT; len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
        end
        8'hC5, 8'hC6, 8'hC7: begin
          op_class = IDC_CLS_EXCHANGE; dst_kind = IDC_OPD_ACC;
          src_kind = (lo == 4'h5) ? IDC_OPD_DIRECT : IDC_OPD_INDIRECT;
          len = (lo == 4'h5) ? `IDC_LEN_TWO : `IDC_LEN_ONE;
        end
        8'hD6, 8'hD7: begin
          op_class = IDC_CLS_LOW_NIBBLE_EXCHANGE; dst_kind = IDC_OPD_ACC;
          src_kind = IDC_OPD_INDIRECT;
        end
        8'hC3, 8'hD3, 8'hB3: begin
          op_class = IDC_CLS_BIT_SET_CLEAR; dst_kind = IDC_OPD_CARRY;
        end
        8'hC2, 8'hD2, 8'hB2: begin
          op_class = IDC_CLS_BIT_SET_CLEAR; dst_kind = IDC_OPD_BIT; len = `IDC_LEN_TWO;
        end
        8'h82, 8'hB0, 8'h72, 8'hA0: begin
          op_class = IDC_CLS_BIT_LOGIC; dst_kind = IDC_OPD_CARRY; src_kind = IDC_OPD_BIT;
          len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
        end
        8'hA2: begin
          op_class = IDC_CLS_BIT_MOVE; dst_kind = IDC_OPD_CARRY; src_kind = IDC_OPD_BIT;
          len = `IDC_LEN_TWO;
        end
        8'h92: begin
          op_class = IDC_CLS_BIT_MOVE; dst_kind = IDC_OPD_BIT; src_kind = IDC_OPD_CARRY;
          len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
        end
        default: begin
          // Banked columns 8..F of rows 7,8,A,C,F
          if (lo >= 4'h8 && (hi == 4'h7 || hi == 4'h8 || hi == 4'hA ||
                             hi == 4'hC || hi == 4'hF)) begin
            op_class = (hi == 4'hC) ? IDC_CLS_EXCHANGE : IDC_CLS_MOVE;
            case (hi)
              4'h7: begin
                dst_kind = IDC_OPD_BANK; src_kind = IDC_OPD_IMMEDIATE; len = `IDC_LEN_TWO;
              end
              4'h8: begin
                dst_kind = IDC_OPD_DIRECT; src_kind = IDC_OPD_BANK;
                len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
              end
              4'hA: begin
                dst_kind = IDC_OPD_BANK; src_kind = IDC_OPD_DIRECT;
                len = `IDC_LEN_TWO; mcycles = `IDC_MC_TWO;
              end
              4'hC: begin dst_kind = IDC_OPD_ACC; src_kind = IDC_OPD_BANK; end
              default: begin dst_kind = IDC_OPD_BANK; src_kind = IDC_OPD_ACC; end
            endcase
          end else begin
            known = 1'b0;
          end
        end
      endcase
    end
  end
endmodule : idc_table

// *** core/idc_decoder.sv ***
// Instruction decoder with operand fetch and machine-cycle timing
`timescale 1ns/1ps
`include "idc_cfg.svh"
module idc_decoder
  import idc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        code_valid,
  input  wire logic [7:0]  code_byte,
  output logic             code_ready,
  output logic             issue,
  output logic [7:0]       opcode,
  output logic [7:0]       operand_1,
  output logic [7:0]       operand_2,
  output logic [1:0]       length,
  output logic [2:0]       machine_cycles,
  output idc_class_e       op_class,
  output idc_opd_e         dst_kind,
  output idc_opd_e         src_kind,
  output logic [2:0]       bank_register,
  output logic             indirect_pointer_register,
  output logic             illegal,
  output logic             busy,
  output logic             mc_phase
);
  import idc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode table
  idc_class_e t_class;
  idc_opd_e   t_dst;
  idc_opd_e   t_src;
  logic [1:0] t_len;
  logic [2:0] t_mc;
  logic       t_known;

  idc_table u_table (
    .opcode   (opcode),
    .op_class (t_class),
    .dst_kind (t_dst),
    .src_kind (t_src),
    .len      (t_len),
    .mcycles  (t_mc),
    .known    (t_known)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle phase
  logic       next_mc_phase;
  always_comb begin
    next_mc_phase = ~mc_phase;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mc_phase <= 1'b0;
    end else begin
      mc_phase <= next_mc_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch and execute sequencer
  idc_state_e state;
  idc_state_e next_state;
  logic [1:0] got;
  logic [1:0] next_got;
  logic [3:0] clk_left;
  logic [3:0] next_clk_left;
  logic [7:0] next_opcode;
  logic [7:0] next_operand_1;
  logic [7:0] next_operand_2;
  logic       next_issue;
  logic       next_busy;
  logic       next_code_ready;
  logic [1:0] next_length;
  logic [2:0] next_machine_cycles;
  idc_class_e next_op_class;
  idc_opd_e   next_dst_kind;
  idc_opd_e   next_src_kind;
  logic [2:0] next_bank_register;
  logic       next_indirect_ptr;
  logic       next_illegal;
  logic       take;

  always_comb begin
    next_state          = state;
    next_got            = got;
    next_clk_left       = clk_left;
    next_opcode         = opcode;
    next_operand_1      = operand_1;
    next_operand_2      = operand_2;
    next_issue          = 1'b0;
    next_busy           = busy;
    next_code_ready     = code_ready;
    next_length         = length;
    next_machine_cycles = machine_cycles;
    next_op_class       = op_class;
    next_dst_kind       = dst_kind;
    next_src_kind       = src_kind;
    next_bank_register  = bank_register;
    next_indirect_ptr   = indirect_pointer_register;
    next_illegal        = illegal;
    take                = code_valid && code_ready;
    case (state)
      IDC_ST_IDLE: begin
        next_code_ready = 1'b1;
        next_busy       = 1'b0;
        if (take) begin
          next_opcode     = code_byte;
          next_got        = 2'h1;
          next_state      = IDC_ST_FETCH;
          next_code_ready = 1'b0;
          next_busy       = 1'b1;
        end
      end
      IDC_ST_FETCH: begin
        if (got >= t_len) begin
          next_length         = t_len;
          next_machine_cycles = t_mc;
          next_op_class       = t_class;
          next_dst_kind       = t_dst;
          next_src_kind       = t_src;
          next_bank_register  = opcode[`IDC_BANK_LSB +: `IDC_BANK_W];
          next_indirect_ptr   = opcode[`IDC_PTR_BIT];
          next_illegal        = ~t_known;
          next_issue          = 1'b1;
          next_code_ready     = 1'b0;
          next_clk_left       = 4'(t_mc * `IDC_CLK_PER_MC);
          next_state          = IDC_ST_EXEC;
        end else begin
          next_code_ready = 1'b1;
          if (take) begin
            if (got == 2'h1) begin
              next_operand_1 = code_byte;
            end else begin
              next_operand_2 = code_byte;
            end
            next_got        = got + 2'h1;
            next_code_ready = 1'b0;
          end
        end
      end
      IDC_ST_EXEC: begin
        if (clk_left == 4'h1) begin
          next_state      = IDC_ST_IDLE;
          next_code_ready = 1'b1;
          next_busy       = 1'b0;
        end else begin
          next_clk_left = clk_left - 4'h1;
        end
      end
      default: begin
        next_state = IDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                     <= IDC_ST_IDLE;
      got                       <= 2'h0;
      clk_left                  <= 4'h0;
      opcode                    <= `IDC_NOP_OPCODE;
      operand_1                 <= 8'h00;
      operand_2                 <= 8'h00;
      issue                     <= 1'b0;
      busy                      <= 1'b0;
      code_ready                <= 1'b0;
      length                    <= `IDC_LEN_ONE;
      machine_cycles            <= `IDC_MC_ONE;
      op_class                  <= IDC_CLS_NONE;
      dst_kind                  <= IDC_OPD_NONE;
      src_kind                  <= IDC_OPD_NONE;
      bank_register             <= 3'h0;
      indirect_pointer_register <= 1'b0;
      illegal                   <= 1'b0;
    end else begin
      state                     <= next_state;
      got                       <= next_got;
      clk_left                  <= next_clk_left;
      opcode                    <= next_opcode;
      operand_1                 <= next_operand_1;
      operand_2                 <= next_operand_2;
      issue                     <= next_issue;
      busy                      <= next_busy;
      code_ready                <= next_code_ready;
      length                    <= next_length;
      machine_cycles            <= next_machine_cycles;
      op_class                  <= next_op_class;
      dst_kind                  <= next_dst_kind;
      src_kind                  <= next_src_kind;
      bank_register             <= next_bank_register;
      indirect_pointer_register <= next_indirect_ptr;
      illegal                   <= next_illegal;
    end
  end
endmodule : idc_decoder

// *** bench/idc_decoder_chk.sv ***
// Concurrent checks on the instruction decoder ports
`timescale 1ns/1ps
module idc_decoder_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       code_valid,
  input wire logic [7:0] code_byte,
  input wire logic       code_ready,
  input wire logic       issue,
  input wire logic [7:0] opcode,
  input wire logic [1:0] length,
  input wire logic [2:0] machine_cycles,
  input wire logic [2:0] bank_register,
  input wire logic       indirect_pointer_register,
  input wire logic       busy,
  input wire logic       mc_phase
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take_op;
    code_valid && code_ready && !busy;
  endsequence
  sequence s_issue1;
    issue && machine_cycles == 3'h1;
  endsequence
  sequence s_issue2;
    issue && machine_cycles == 3'h2;
  endsequence
  sequence s_issue4;
    issue && machine_cycles == 3'h4;
  endsequence
  sequence s_back;
    code_ready && !busy;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  property p_mc_toggle;
    $past(rst_n) |-> mc_phase != $past(mc_phase);
  endproperty
  property p_exec1;
    s_issue1 |-> (busy && !code_ready)[*2] ##1 s_back;
  endproperty
  property p_exec2;
    s_issue2 |-> (busy && !code_ready)[*4] ##1 s_back;
  endproperty
  property p_exec4;
    s_issue4 |-> (busy && !code_ready)[*8] ##1 s_back;
  endproperty
  property p_mc_legal;
    issue |-> machine_cycles == 3'h1 || machine_cycles == 3'h2 || machine_cycles == 3'h4;
  endproperty
  property p_len_legal;
    issue |-> length != 2'h0;
  endproperty
  property p_take;
    s_take_op |=> busy && !code_ready;
  endproperty
  property p_one_byte;
    issue && length == 2'h1 |-> $past(code_valid, 2) && $past(code_ready, 2)
      && $past(code_byte, 2) == opcode;
  endproperty
  property p_bank;
    issue |-> bank_register == opcode[2:0];
  endproperty
  property p_ptr;
    issue |-> indirect_pointer_register == opcode[0];
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_mc_toggle: assert property (p_mc_toggle) else $error("phase did not toggle");
  a_exec1: assert property (p_exec1) else $error("one cycle exec length wrong");
  a_exec2: assert property (p_exec2) else $error("two cycle exec length wrong");
  a_exec4: assert property (p_exec4) else $error("four cycle exec length wrong");
  a_mc_legal: assert property (p_mc_legal) else $error("bad cycle count");
  a_len_legal: assert property (p_len_legal) else $error("bad length");
  a_take: assert property (p_take) else $error("opcode take not followed by busy");
  a_one_byte: assert property (p_one_byte) else $error("single byte issue late");
  a_bank: assert property (p_bank) else $error("bank register field wrong");
  a_ptr: assert property (p_ptr) else $error("pointer select wrong");
endmodule : idc_decoder_chk

// *** bench/test_idc_decoder.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module test_idc_decoder;
  import idc_pkg::*;
  localparam logic [5:0] L11 = 6'h29;
  localparam logic [5:0] L21 = 6'h31;
  localparam logic [5:0] L12 = 6'h2A;
  localparam logic [5:0] L14 = 6'h2C;
  localparam logic [5:0] L22 = 6'h32;
  localparam logic [5:0] L32 = 6'h3A;
  localparam logic [5:0] ILL = 6'h09;
  logic        clk;
  logic        rst_n;
  logic        code_valid;
  logic [7:0]  code_byte;
  logic        code_ready;
  logic        issue;
  logic [7:0]  opcode;
  logic [7:0]  operand_1;
  logic [7:0]  operand_2;
  logic [1:0]  length;
  logic [2:0]  machine_cycles;
  idc_class_e  op_class;
  idc_opd_e    dst_kind;
  idc_opd_e    src_kind;
  logic [2:0]  bank_register;
  logic        indirect_pointer_register;
  logic        illegal;
  logic        busy;
  logic        mc_phase;
  int          fails;
  int          checked;
  int          seed;
  logic [29:0] notes[$];
  logic [29:0] nt;
  logic [7:0]  rop;

  idc_decoder dut (.clk(clk), .rst_n(rst_n), .code_valid(code_valid), .code_byte(code_byte),
    .code_ready(code_ready), .issue(issue), .opcode(opcode), .operand_1(operand_1),
    .operand_2(operand_2), .length(length), .machine_cycles(machine_cycles),
    .op_class(op_class), .dst_kind(dst_kind), .src_kind(src_kind),
    .bank_register(bank_register), .indirect_pointer_register(indirect_pointer_register),
    .illegal(illegal), .busy(busy), .mc_phase(mc_phase));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Expected {legal, length, cycles}
  function automatic logic [5:0] ref_info(input logic [7:0] op);
    logic [3:0] h;
    logic [3:0] l;
    h = op[7:4];
    l = op[3:0];
    if (l >= 4'h6) begin
      if (h == 4'hB || (h == 4'hD && l >= 4'h8)) ref_info = ILL;
      else if (h == 4'h8 || h == 4'hA) ref_info = L22;
      else if (h == 4'h7) ref_info = L21;
      else ref_info = L11;
    end else begin
      case (op)
        8'h03, 8'h13, 8'h23, 8'h33, 8'h04, 8'h14, 8'hB3, 8'hC3, 8'hD3, 8'hC4, 8'hD4,
        8'hE4, 8'hF4: ref_info = L11;
        8'hA3, 8'h93, 8'h83, 8'hE2, 8'hE3, 8'hE0, 8'hF2, 8'hF3, 8'hF0: ref_info = L12;
        8'hA4, 8'h84: ref_info = L14;
        8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90: ref_info = L32;
        8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92, 8'hC0, 8'hD0: ref_info = L22;
        8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h44, 8'h45, 8'h42, 8'h54, 8'h55, 8'h52,
        8'h64, 8'h65, 8'h62, 8'h74, 8'h94, 8'h95, 8'hC5, 8'hE5, 8'hF5, 8'hA2, 8'hB2, 8'hC2,
        8'hD2: ref_info = L21;
        default: ref_info = ILL;
      endcase
    end
  endfunction : ref_info

  function automatic idc_class_e cls_of(input logic [7:0] op);
    cls_of = IDC_CLS_NONE;
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h2) cls_of = IDC_CLS_ADD;
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h3) cls_of = IDC_CLS_ADD_WITH_CARRY;
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h9) cls_of = IDC_CLS_SUBTRACT_WITH_BORROW;
    if (op[3:0] >= 4'h2 && op[7:4] == 4'h5) cls_of = IDC_CLS_AND;
    if (op[3:0] >= 4'h2 && op[7:4] == 4'h4) cls_of = IDC_CLS_OR;
    if (op[3:0] >= 4'h2 && op[7:4] == 4'h6) cls_of = IDC_CLS_XOR;
    if (op[3:0] == 4'h3 && op[7:6] == 2'h0) cls_of = IDC_CLS_ROTATE;
    if (op[3:0] >= 4'h5 && op[7:4] == 4'hC) cls_of = IDC_CLS_EXCHANGE;
    case (op)
      8'h90: cls_of = IDC_CLS_LOAD_DATA_POINTER;
      8'h93, 8'h83: cls_of = IDC_CLS_CODE_MEMORY_READ;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: cls_of = IDC_CLS_EXTERNAL_DATA_MOVE;
      8'hC0: cls_of = IDC_CLS_PUSH;
      8'hD0: cls_of = IDC_CLS_POP;
      8'hD6, 8'hD7: cls_of = IDC_CLS_LOW_NIBBLE_EXCHANGE;
      8'h82, 8'hB0, 8'h72, 8'hA0: cls_of = IDC_CLS_BIT_LOGIC;
      8'hA4: cls_of = IDC_CLS_MULTIPLY;
      8'h84: cls_of = IDC_CLS_DIVIDE;
      default: ;
    endcase
  endfunction : cls_of

  // Expected {dst_kind, src_kind}; all ones where not predicted
  function automatic logic [5:0] kind_of(input logic [7:0] op);
    kind_of = 6'h3F;
    if (op[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hE}) begin
      if (op[3:0] >= 4'h8) kind_of = {IDC_OPD_ACC, IDC_OPD_BANK};
      else if (op[3:0] >= 4'h6) kind_of = {IDC_OPD_ACC, IDC_OPD_INDIRECT};
      else if (op[3:0] == 4'h5) kind_of = {IDC_OPD_ACC, IDC_OPD_DIRECT};
    end
    if (op[7:3] == 5'h1F) kind_of = {IDC_OPD_BANK, IDC_OPD_ACC};
  endfunction : kind_of
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("Counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    code_valid = 1'b1;
    code_byte = b;
    while (code_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) chk("handshake", 32'h0, 32'h1);
    @(posedge clk);
    #1;
  endtask : put

  task automatic pause;
    int g;
    g = {$random(seed)} % 3;
    if (g > 0) begin
      code_valid = 1'b0;
      code_byte = ~code_byte;
      repeat (g) @(posedge clk);
      #1;
    end
  endtask : pause

  task automatic send_instr(input logic [7:0] op);
    logic [5:0] inf;
    logic [7:0] b1;
    logic [7:0] b2;
    inf = ref_info(op);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    put(op);
    if (inf[4:3] > 2'h1) begin
      pause();
      put(b1);
    end
    if (inf[4:3] == 2'h3) begin
      pause();
      put(b2);
    end
    notes.push_back({op, b1, b2, inf});
    pause();
  endtask : send_instr
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (issue === 1'b1) begin
      if (notes.size() == 0) chk("unexpected issue", 32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        chk("opcode", opcode, nt[29:22]);
        chk("length", length, nt[4:3]);
        chk("cycles", machine_cycles, nt[2:0]);
        chk("illegal", illegal, !nt[5]);
        if (nt[4:3] > 2'h1) chk("operand_1", operand_1, nt[21:14]);
        if (nt[4:3] == 2'h3) chk("operand_2", operand_2, nt[13:6]);
        if (cls_of(nt[29:22]) != IDC_CLS_NONE) chk("class", op_class, cls_of(nt[29:22]));
        chk("bank", bank_register, nt[24:22]);
        chk("pointer", indirect_pointer_register, nt[22]);
        if (kind_of(nt[29:22]) != 6'h3F)
          chk("kinds", {dst_kind, src_kind}, kind_of(nt[29:22]));
      end
    end
  end

  initial begin
    #(25 * 60000);
    fails++;
    close_out();
  end

  initial begin
    seed = 30;
    fails = 0;
    checked = 0;
    rst_n = 1'b0;
    code_valid = 1'b0;
    code_byte = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    for (int i = 0; i < 256; i++) send_instr(8'(i));
    $display("test opcode sweep done");
    for (int i = 0; i < 300; i++) begin
      rop = 8'($random(seed));
      send_instr(rop);
    end
    $display("test random stream done");
    put(8'h85);
    put(8'h3C);
    code_valid = 1'b0;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk("ready in reset", code_ready, 32'h0);
    chk("busy in reset", busy, 32'h0);
    chk("issue in reset", issue, 32'h0);
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    send_instr(8'h85);
    send_instr(8'hA4);
    send_instr(8'h53);
    $display("test abort by reset done");
    repeat (20) @(posedge clk);
    chk("notes left", notes.size(), 32'h0);
    close_out();
  end
endmodule : test_idc_decoder

bind idc_decoder idc_decoder_chk u_chk (.clk(clk), .rst_n(rst_n), .code_valid(code_valid),
  .code_byte(code_byte), .code_ready(code_ready), .issue(issue), .opcode(opcode),
  .length(length), .machine_cycles(machine_cycles), .bank_register(bank_register),
  .indirect_pointer_register(indirect_pointer_register), .busy(busy), .mc_phase(mc_phase));
